/* design/rlnc_core.v */
// execution of the rotate-left-no-carry instruction over four q phases
// Summary of operation
// - decode 0100 01da opcode, rotate left one bit
// - d equal 0 writes working register
// - d equal 1 writes back source register
// - a selects access bank or bank select
// - extended set, a=0, f<=5Fh uses indexed offset
// - decode Q1, read Q2, rotate Q3, write Q4
// - only negative and zero flags change
`timescale 1ns/1ps
`default_nettype none
`include "rlnc_defines.vh"
module rlnc_core (
   // clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // instruction stream, one word per instruction cycle
   input wire insn_valid_i,
   input wire [15:0] insn_i,
   input wire ext_set_en_i,
   input wire [3:0] bank_select_register_i,
   input wire [7:0] index_base_i,
   // data memory port
   output reg [11:0] mem_addr_o,
   output reg mem_wr_o,
   output reg [7:0] mem_wdata_o,
   input wire [7:0] mem_rdata_i,
   // working register and status flags
   output reg [7:0] wreg_o,
   output reg neg_flag_o,
   output reg zero_flag_o,
   output reg busy_o,
   output reg done_o
);

   // one-hot phase codes, q1 doubles as idle
   localparam [3:0] ST_Q1 = 4'h1;
   localparam [3:0] ST_Q2 = 4'h2;
   localparam [3:0] ST_Q3 = 4'h4;
   localparam [3:0] ST_Q4 = 4'h8;

   // phase state
   reg [3:0] state_q;
   reg [3:0] state_d;
   // destination select latched at take
   reg dest_q;
   reg dest_d;
   // operand byte, read in q2 and rotated in q3
   reg [7:0] rot_q;
   reg [7:0] rot_d;
   // next values of the memory port outputs
   reg [11:0] mem_addr_d;
   reg mem_wr_d;
   reg [7:0] mem_wdata_d;
   // next values of working register and flags
   reg [7:0] wreg_d;
   reg neg_d;
   reg zero_d;
   // next values of phase status outputs
   reg busy_d;
   reg done_d;
   // address calculation
   reg [8:0] idx_sum;
   reg [7:0] addr_off;
   reg [11:0] addr_calc;
   // decoded fields
   wire is_op;
   wire take;
   wire [7:0] f_field;
   wire d_field;
   wire a_field;
   wire [7:0] rot_res;

   // instruction fields
   assign f_field = insn_i[`RLNC_F_HI];
   assign d_field = insn_i[`RLNC_D_BIT];
   assign a_field = insn_i[`RLNC_A_BIT];

   // opcode match, word taken only while idle in q1
   assign is_op = (insn_i[`RLNC_OPC_HI] == `RLNC_OPC_VAL);
   assign take = (state_q == ST_Q1) && insn_valid_i && is_op;

   // left rotate, msb wraps into lsb, no carry path
   assign rot_res = {rot_q[`RLNC_LSBS], rot_q[`RLNC_MSB]};

   // indexed offset sum, carry out dropped on purpose
   always @* begin
      idx_sum = {`RLNC_BIT_CLR, index_base_i} + {`RLNC_BIT_CLR, f_field};
   end

   // effective address from access bit, bank and indexed mode
   always @* begin
      addr_off = f_field;
      addr_calc = {`RLNC_ACC_LO_BANK, f_field};
      if (a_field) begin
         addr_calc = {bank_select_register_i, f_field};
      end else if (ext_set_en_i && (f_field <= `RLNC_ILO_MAX)) begin
         addr_off = idx_sum[`RLNC_F_HI];
         addr_calc = {`RLNC_ACC_LO_BANK, addr_off};
      end else if (f_field < `RLNC_ACC_SPLIT) begin
         addr_calc = {`RLNC_ACC_LO_BANK, f_field};
      end else begin
         addr_calc = {`RLNC_ACC_HI_BANK, f_field};
      end
   end

   // phase sequencer, one pass per taken word
   always @* begin
      case (state_q)
         ST_Q1: begin
            state_d = take ? ST_Q2 : ST_Q1;
         end
         ST_Q2: begin
            state_d = ST_Q3;
         end
         ST_Q3: begin
            state_d = ST_Q4;
         end
         ST_Q4: begin
            state_d = ST_Q1;
         end
         default: begin
            state_d = ST_Q1;
         end
      endcase
   end

   // destination select kept for the q4 write
   always @* begin
      dest_d = dest_q;
      if (take) begin
         dest_d = d_field;
      end
   end

   // operand capture in q2, rotate in q3
   always @* begin
      case (state_q)
         ST_Q2: begin
            rot_d = mem_rdata_i;
         end
         ST_Q3: begin
            rot_d = rot_res;
         end
         default: begin
            rot_d = rot_q;
         end
      endcase
   end

   // operand address, held from q2 until the next take
   always @* begin
      mem_addr_d = mem_addr_o;
      if (take) begin
         mem_addr_d = addr_calc;
      end
   end

   // write back to the file register in q4 when d is set
   always @* begin
      mem_wr_d = `RLNC_BIT_CLR;
      mem_wdata_d = mem_wdata_o;
      if ((state_q == ST_Q4) && dest_q) begin
         mem_wr_d = `RLNC_BIT_SET;
         mem_wdata_d = rot_q;
      end
   end

   // working register load in q4 when d is clear
   always @* begin
      wreg_d = wreg_o;
      if ((state_q == ST_Q4) && !dest_q) begin
         wreg_d = rot_q;
      end
   end

   // negative and zero flags only; carry is not touched
   always @* begin
      neg_d = neg_flag_o;
      zero_d = zero_flag_o;
      if (state_q == ST_Q4) begin
         neg_d = rot_q[`RLNC_MSB];
         zero_d = (rot_q == `RLNC_ZERO8);
      end
   end

   // busy from take through q4, done pulse after q4
   always @* begin
      busy_d = busy_o;
      done_d = `RLNC_BIT_CLR;
      if (take) begin
         busy_d = `RLNC_BIT_SET;
      end
      if (state_q == ST_Q4) begin
         busy_d = `RLNC_BIT_CLR;
         done_d = `RLNC_BIT_SET;
      end
   end

   // phase state and operand registers
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state_q <= ST_Q1;
         dest_q <= `RLNC_BIT_CLR;
         rot_q <= `RLNC_ZERO8;
      end else begin
         state_q <= state_d;
         dest_q <= dest_d;
         rot_q <= rot_d;
      end
   end

   // data memory port registers
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         mem_addr_o <= `RLNC_ADDR_RST;
         mem_wr_o <= `RLNC_BIT_CLR;
         mem_wdata_o <= `RLNC_ZERO8;
      end else begin
         mem_addr_o <= mem_addr_d;
         mem_wr_o <= mem_wr_d;
         mem_wdata_o <= mem_wdata_d;
      end
   end

   // working register and status flag registers
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         wreg_o <= `RLNC_ZERO8;
         neg_flag_o <= `RLNC_BIT_CLR;
         zero_flag_o <= `RLNC_BIT_CLR;
      end else begin
         wreg_o <= wreg_d;
         neg_flag_o <= neg_d;
         zero_flag_o <= zero_d;
      end
   end

   // phase status registers
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         busy_o <= `RLNC_BIT_CLR;
         done_o <= `RLNC_BIT_CLR;
      end else begin
         busy_o <= busy_d;
         done_o <= done_d;
      end
   end

   // note: a word offered while busy is simply not taken
   // note: the indexed base is a plain 8-bit value
   // note: only the low byte of the sum reaches the bus
   // note: bank select is sampled at take only
   // note: the access split sits at the indexed limit plus one
   // note: read data must settle within the q2 cycle
endmodule
`default_nettype wire

/* design/rlnc_defines.vh */
// constants for the rotate-left-no-carry execution block
`ifndef RLNC_DEFINES_VH
`define RLNC_DEFINES_VH
`define RLNC_OPC_HI 15:10
`define RLNC_OPC_VAL 6'h11
`define RLNC_D_BIT 9
`define RLNC_A_BIT 8
`define RLNC_F_HI 7:0
`define RLNC_ILO_MAX 8'h5F
`define RLNC_ACC_SPLIT 8'h60
`define RLNC_ACC_HI_BANK 4'hF
`define RLNC_ACC_LO_BANK 4'h0
`define RLNC_ZERO8 8'h00
`define RLNC_MSB 7
`define RLNC_LSBS 6:0
`define RLNC_ADDR_RST 12'h000
`define RLNC_BIT_CLR 1'h0
`define RLNC_BIT_SET 1'h1
`endif

/* verif/rlnc_core_monitor.sv */
// checker for the rotate block
`timescale 1ns/1ps
`default_nettype none
module rlnc_core_monitor (
   // clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // instruction side
   input wire insn_valid_i,
   input wire [15:0] insn_i,
   // results
   input wire busy_o,
   input wire done_o,
   input wire mem_wr_o,
   input wire neg_flag_o,
   input wire zero_flag_o,
   input wire [7:0] mem_wdata_o
);
   wire take;
   // a word is taken only while idle
   assign take = insn_valid_i && (insn_i[15:10] == 6'h11) && !busy_o;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // phase timing, write strobe and flags
   a_q_phase: assert property (take |=>
      busy_o [*3] ##1 (done_o && !busy_o)) else $error("q");
   a_dest_file: assert property (take && insn_i[9] |-> ##4 (done_o && mem_wr_o))
      else $error("dest file");
   a_dest_wreg: assert property (take && !insn_i[9] |-> ##4 (done_o && !mem_wr_o))
      else $error("dest wreg");
   a_flag_hold: assert property (!done_o |-> $stable(neg_flag_o) && $stable(zero_flag_o))
      else $error("flags moved");
   a_idle_quiet: assert property (!busy_o && !take |=> !busy_o)
      else $error("idle");
   cover property (done_o && mem_wr_o);
   cover property (done_o && !mem_wr_o && neg_flag_o);
   a_wr_pulse: assert property (mem_wr_o |-> done_o ##1 !mem_wr_o) else $error("w");
   a_flag_nz: assert property (done_o && mem_wr_o |->
      neg_flag_o == mem_wdata_o[7] && zero_flag_o == !mem_wdata_o) else $error("f");
   cover property (done_o && zero_flag_o);
endmodule
`default_nettype wire

/* verif/tb_rlnc_core.sv */
// rotate block bench
`timescale 1ns/1ps
`default_nettype none
module tb_rlnc_core;
   reg core_clk_i = 0, resetn_i = 0, insn_valid_i = 0, ext_set_en_i = 0;
   reg [15:0] insn_i = 16'h0000;
   reg [3:0] bank_select_register_i = 4'h3;
   reg [7:0] index_base_i = 8'hA3, mem_rdata_i = 8'h00;
   wire [11:0] mem_addr_o;
   wire [7:0] mem_wdata_o, wreg_o;
   wire mem_wr_o, neg_flag_o, zero_flag_o, busy_o, done_o;
   integer err_total = 0, check_count = 0, n, ndone;
   always #5 core_clk_i = ~core_clk_i;
   rlnc_core dut (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .insn_valid_i(insn_valid_i),
      .insn_i(insn_i),
      .ext_set_en_i(ext_set_en_i),
      .bank_select_register_i(bank_select_register_i),
      .index_base_i(index_base_i),
      .mem_addr_o(mem_addr_o),
      .mem_wr_o(mem_wr_o),
      .mem_wdata_o(mem_wdata_o),
      .mem_rdata_i(mem_rdata_i),
      .wreg_o(wreg_o),
      .neg_flag_o(neg_flag_o),
      .zero_flag_o(zero_flag_o),
      .busy_o(busy_o),
      .done_o(done_o)
   );
   // a non-matching word must leave the block idle
   task ignore_other(input [15:0] i);
      begin
         @(posedge core_clk_i) #1 {insn_valid_i, insn_i} = {1'h1, i};
         @(posedge core_clk_i) #1 insn_valid_i = 1'h0;
         check_count++;
         for (n = 0; n < 6; n++) begin
            if (busy_o !== 1'h0 || done_o !== 1'h0 || mem_wr_o !== 1'h0) begin
               err_total++;
               $display("ERROR %0t foreign word acted on", $time);
            end
            @(posedge core_clk_i) #1;
         end
      end
   endtask
   // a word held valid while busy must not start a second pass
   task refuse_busy;
      begin
         @(posedge core_clk_i) #1 {insn_valid_i, insn_i, mem_rdata_i} = {1'h1, 16'h4660, 8'h81};
         @(posedge core_clk_i) #1;
         @(posedge core_clk_i) #1;
         @(posedge core_clk_i) #1 insn_valid_i = 1'h0;
         ndone = 0;
         for (n = 0; n < 10; n++) begin
            if (done_o === 1'h1) ndone++;
            @(posedge core_clk_i) #1;
         end
         check_count++;
         if (ndone !== 1 || mem_wdata_o !== 8'h03) begin
            err_total++;
            $display("ERROR %0t word taken while busy", $time);
         end
      end
   endtask
   task op(input [15:0] i, input [7:0] v, input [11:0] a);
      begin
         @(posedge core_clk_i) #1 {insn_valid_i, insn_i, mem_rdata_i} = {1'h1, i, v};
         @(posedge core_clk_i) #1 insn_valid_i = 1'h0;
         check_count++;
         if (busy_o !== 1'h1) begin
            err_total++;
            $display("ERROR %0t busy not raised", $time);
         end
         for (n = 0; n < 9 && done_o !== 1'h1; n++) @(posedge core_clk_i) #1;
         if (done_o !== 1'h1) begin
            err_total++;
            $display("ERROR %0t done timeout", $time);
            results;
         end
         v = {v[6:0], v[7]};
         check_count++;
         if ({done_o, mem_addr_o, mem_wr_o, neg_flag_o, zero_flag_o} !==
            {1'b1, a, i[9], v[7], !v} || (i[9] ? mem_wdata_o : wreg_o) !== v) begin
            err_total++;
            $display("ERROR %0t mismatch", $time);
         end
      end
   endtask
   task results;
      begin
         $display("checks %0d errors %0d", check_count, err_total);
         if (err_total == 0 && check_count > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   // reset, then access high, bank select and indexed words; access low is not driven
   initial begin
      repeat (12) @(posedge core_clk_i);
      #1 resetn_i = 1;
      op(16'h4660, 8'h00, 12'hF60);
      op(16'h4580, 8'h80, 12'h380);
      ignore_other(16'h4860);
      refuse_busy;
      ext_set_en_i = 1'h1;
      op(16'h445F, 8'h7F, 12'h002);
      op(16'h4580, 8'h80, 12'h380);
      op(16'h4460, 8'h01, 12'hF60);
      results;
   end
endmodule
bind rlnc_core rlnc_core_monitor mon (
   .core_clk_i(core_clk_i),
   .resetn_i(resetn_i),
   .insn_valid_i(insn_valid_i),
   .insn_i(insn_i),
   .busy_o(busy_o),
   .done_o(done_o),
   .mem_wr_o(mem_wr_o),
   .neg_flag_o(neg_flag_o),
   .zero_flag_o(zero_flag_o),
   .mem_wdata_o(mem_wdata_o)
);
`default_nettype wire
